/* File: dv/rtcc_bus_master.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_params.svh"

module rtcc_bus_master (
  // Clock
  input wire logic i_clk,
  // Register port
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  // Bus lines, pulled high when released
  output logic o_sda,
  output logic o_scl
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_sda = 1'b1;
    o_scl = 1'b1;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1 o_wr = 1'b0;
    @(posedge i_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1 o_rd = 1'b0;
    d = i_rdata;
    @(posedge i_clk);
    #1;
  endtask : rd

  // One held phase, a little past the minimum
  task automatic phase(input logic scl);
    o_scl = scl;
    o_sda = 1'b0;
    repeat (`RTCC_OVR_HOLD_CYC + 4) @(posedge i_clk);
    #1;
  endtask : phase

  task automatic ovr_seq();
    phase(1'b1);
    phase(1'b0);
    phase(1'b1);
    o_sda = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : ovr_seq
endmodule : rtcc_bus_master
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_params.svh"

module testbench;
  import rtcc_pkg::*;
  logic i_clk, i_sys_rst, osc_ready, pin_drv, pin_w, cent;
  logic reg_wr, reg_rd, sda, scl, sqw_o, sqw_oe, flag, ext_mode, por, ovr, tick64, sqw_src;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, lf, mo, yv;
  logic [7:0] rst_a [7] = '{8'h00, 8'h02, 8'h05, 8'h07, 8'h09, 8'h0c, 8'h0d};
  logic [7:0] rst_v [7] = '{8'h08, 8'h80, 8'h01, 8'h01, 8'h80, 8'h80, 8'h00};
  int num_checks, miscompares;

  // Pin level: design drives unless in test mode
  assign pin_w = sqw_oe ? sqw_o : pin_drv;

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  rtcc_calendar_alarm_core DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_tick_64hz(tick64), .i_osc_ready(osc_ready), .i_osc_fail(1'b0),
    .i_sqw_source(sqw_src), .i_square_wave_pin(pin_w),
    .o_square_wave_pin(sqw_o), .o_square_wave_pin_oe(sqw_oe),
    .i_sda(sda), .i_scl(scl), .o_alarm_hit_flag(flag),
    .o_external_tick_mode(ext_mode), .o_por_active(por), .o_override_active(ovr)
  );

  rtcc_bus_master BM (
    .i_clk(i_clk), .o_wr(reg_wr), .o_rd(reg_rd), .o_addr(reg_addr),
    .o_wdata(reg_wdata), .i_rdata(reg_rdata), .o_sda(sda), .o_scl(scl)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : inc

  function automatic logic [7:0] dmax(input logic [7:0] m, input logic [7:0] y);
    int yr;
    yr = y[7:4] * 10 + y[3:0];
    if (m == 8'h02) return (yr % 4 == 0) ? 8'h29 : 8'h28;
    if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return 8'h30;
    return 8'h31;
  endfunction : dmax

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  // Internal tick pulsed between pin edges; test mode must ignore it
  task automatic pulses(input int n);
    repeat (n) begin
      pin_drv = 1'b1;
      tick64 = 1'b0;
      cyc(1);
      pin_drv = 1'b0;
      tick64 = 1'b1;
      cyc(1);
    end
    tick64 = 1'b0;
  endtask : pulses

  // Known prescaler phase, then run into the next minute
  task automatic run_second(input logic [7:0] m);
    BM.wr(`RTCC_ADDR_CS1, 8'ha0);
    pulses(3);
    BM.wr(`RTCC_ADDR_CS1, 8'h80);
    BM.wr(`RTCC_ADDR_SEC, 8'h59);
    BM.wr(`RTCC_ADDR_MIN, m);
    pulses(31);
    BM.rd(`RTCC_ADDR_SEC, rv);
    check(rv, 8'h59);
    pulses(1);
    cyc(3);
  endtask : run_second

  task automatic roll(input logic [7:0] d, input logic [7:0] m, input logic [7:0] y, input logic [2:0] w);
    logic [7:0] ed, em, ey;
    ed = (d == dmax(m, y)) ? 8'h01 : inc(d);
    em = (ed != 8'h01) ? m : (m == 8'h12) ? 8'h01 : inc(m);
    ey = (ed == 8'h01 && m == 8'h12) ? ((y == 8'h99) ? 8'h00 : inc(y)) : y;
    BM.wr(`RTCC_ADDR_HOUR, 8'h23);
    BM.wr(`RTCC_ADDR_DATE, d);
    BM.wr(`RTCC_ADDR_WDAY, {5'h00, w});
    BM.wr(`RTCC_ADDR_MON, {cent, m[6:0]});
    BM.wr(`RTCC_ADDR_YEAR, y);
    run_second(8'h59);
    if (ey == 8'h00 && y == 8'h99) cent = ~cent;
    BM.rd(`RTCC_ADDR_MIN, rv);
    check(rv, 8'h00);
    BM.rd(`RTCC_ADDR_HOUR, rv);
    check(rv, 8'h00);
    BM.rd(`RTCC_ADDR_DATE, rv);
    check(rv, ed);
    BM.rd(`RTCC_ADDR_WDAY, rv);
    check(rv, (w == 3'h6) ? 8'h00 : {5'h00, w + 3'h1});
    BM.rd(`RTCC_ADDR_MON, rv);
    check(rv, {cent, em[6:0]});
    BM.rd(`RTCC_ADDR_YEAR, rv);
    check(rv, ey);
  endtask : roll

  initial begin
    i_sys_rst = 1'b1;
    osc_ready = 1'b0;
    pin_drv = 1'b0;
    tick64 = 1'b0;
    sqw_src = 1'b1;
    cent = 1'b0;
    lf = 8'h12;
    num_checks = 0;
    miscompares = 0;
    cyc(8);
    i_sys_rst = 1'b0;
    cyc(1);
    check({5'h00, sqw_o, sqw_oe, por}, 8'h07);
    for (int i = 0; i < 7; i++) begin
      BM.rd(rst_a[i], rv);
      check(rv, rst_v[i]);
    end
    BM.wr(`RTCC_ADDR_MIN, 8'h33);
    BM.rd(`RTCC_ADDR_MIN, rv);
    check(rv, 8'h00);
    BM.ovr_seq();
    check({6'h00, ovr, por}, 8'h02);
    BM.wr(`RTCC_ADDR_CS1, 8'h00);
    check({6'h00, ovr, por}, 8'h01);
    BM.ovr_seq();
    check({6'h00, ovr, por}, 8'h01);
    osc_ready = 1'b1;
    for (int i = 0; i < 10 && por !== 1'b0; i++) cyc(1);
    if (por !== 1'b0) begin
      miscompares++;
      finish_test();
    end
    BM.wr(`RTCC_ADDR_CS1, 8'h80);
    check({6'h00, sqw_oe, ext_mode}, 8'h01);
    roll(8'h31, 8'h12, 8'h99, 3'h6);
    roll(8'h28, 8'h02, 8'h01, 3'h2);
    roll(8'h28, 8'h02, 8'h00, 3'h0);
    roll(8'h29, 8'h02, 8'h96, 3'h4);
    roll(8'h30, 8'h04, 8'h23, 3'h5);
    repeat (6) begin
      lf = lfsr(lf);
      mo = bcd(lf % 12 + 1);
      lf = lfsr(lf);
      yv = bcd(lf % 100);
      roll(dmax(mo, yv), mo, yv, 3'(lf % 7));
    end
    BM.wr(`RTCC_ADDR_AMIN, 8'h01);
    BM.wr(`RTCC_ADDR_AHOUR, 8'h05);
    BM.wr(`RTCC_ADDR_ADATE, 8'h80);
    BM.wr(`RTCC_ADDR_AWDAY, 8'h80);
    run_second(8'h00);
    check({7'h00, flag}, 8'h00);
    BM.wr(`RTCC_ADDR_AHOUR, 8'h85);
    run_second(8'h00);
    check({7'h00, flag}, 8'h01);
    BM.wr(`RTCC_ADDR_CS2, 8'h08);
    check({7'h00, flag}, 8'h01);
    BM.wr(`RTCC_ADDR_CS2, 8'h00);
    BM.wr(`RTCC_ADDR_MIN, 8'h01);
    check({7'h00, flag}, 8'h00);
    BM.wr(`RTCC_ADDR_MIN, 8'h00);
    BM.wr(`RTCC_ADDR_SEC, 8'h59);
    pulses(64);
    cyc(3);
    BM.rd(`RTCC_ADDR_MIN, rv);
    check(rv, 8'h01);
    check({7'h00, flag}, 8'h01);
    finish_test();
  end
endmodule : testbench
`default_nettype wire

/* File: src/rtcc_bcd_step.sv */
`timescale 1ns/100ps
`default_nettype none

module rtcc_bcd_step (
  // Current value and limits
  input wire logic [7:0] i_val,
  input wire logic [7:0] i_max,
  input wire logic [7:0] i_min,
  // Next value and wrap
  output logic [7:0] o_next,
  output logic o_wrap
);

  always_comb begin
    o_wrap = (i_val >= i_max);
    if (o_wrap) begin
      o_next = i_min;
    end else if (i_val[3:0] >= 4'h9) begin
      o_next = {4'(i_val[7:4] + 4'h1), 4'h0};
    end else begin
      o_next = {i_val[7:4], 4'(i_val[3:0] + 4'h1)};
    end
  end

endmodule : rtcc_bcd_step

`default_nettype wire

/* File: src/rtcc_calendar_alarm_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_params.svh"

// Behaviour
// R1: Weekday counts 0 to 6 then wraps to 0 on next day.
// R2: Date, month and year held as BCD, one digit per nibble.
// R3: Date maximum 31, 30 or 28 by month in ordinary years.
// R4: Years divisible by four, 00 included, let February reach 29.
// R5: Date past month maximum reloads to 1 and increments month.
// R6: Month counts 1 to 12; wrap to 1 increments year.
// R7: Year counts 00 to 99 in BCD, wrapping to 00.
// R8: Century bit 7 of month toggles on year overflow 99 to 00.
// R9: Alarm field compared only when its disable bit is 0.
// R10: Alarm flag set when all enabled comparisons first match together.
// R11: Flag stays set until cleared; sets again only on new matching increment.
// R12: External tick select makes square-wave pin an input replacing 64 Hz tick.
// R13: In test mode pin rising edges divided by 64 into seconds.
// R14: Stop holds prescaler at zero until stop is cleared.
// R15: After stop release first second at 32nd edge, then every 64.
// R16: Software pulses stop after entering test mode; prescaler state unknown.
// R17: Recognised override sequence immediately releases internal power-on reset.
// R18: Writing 0 to override permit leaves override mode, nothing else. Code re-asserts power-on reset if override was active and oscillator not ready.
// R19: Override entry accepted only while override permit is 1.
// R20: Override detected from ordered data/clock line steps, each held a minimum.
// R21: Alarm evaluated on minute-or-higher increments, once per matching minute.
// R22: Stop clears divider chain and halts timekeeping; square wave stays.
// R23: Seconds and minutes count 00 to 59 in BCD and carry.
// R24: Hour wrap 23 to 00 increments date and weekday.
// R25: Writing 0 clears alarm flag; writing 1 leaves it.
module rtcc_calendar_alarm_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register access port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Time base and oscillator status
  input wire logic i_tick_64hz,
  input wire logic i_osc_ready,
  input wire logic i_osc_fail,
  input wire logic i_sqw_source,
  // Square-wave pin
  input wire logic i_square_wave_pin,
  output logic o_square_wave_pin,
  output logic o_square_wave_pin_oe,
  // Two-wire bus lines, observed only
  input wire logic i_sda,
  input wire logic i_scl,
  // Status
  output logic o_alarm_hit_flag,
  output logic o_external_tick_mode,
  output logic o_por_active,
  output logic o_override_active
);
  import rtcc_pkg::*;

  rtcc_state_t q;
  rtcc_state_t d;

  logic tick;
  logic hold;
  logic sec_inc;
  logic min_inc;
  logic hour_inc;
  logic day_inc;
  logic mon_inc;
  logic year_inc;
  logic cent_flip;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic date_wrap;
  logic mon_wrap;
  logic year_wrap;
  logic [7:0] sec_next;
  logic [7:0] min_next;
  logic [7:0] hour_next;
  logic [7:0] date_next;
  logic [7:0] mon_next;
  logic [7:0] year_next;
  logic [7:0] date_max;
  logic leap;
  logic any_en;
  logic match;
  logic af_set;
  logic wr;
  logic cnt_ok;
  logic ovr_enter;
  logic [7:0] rd_mux;

  // Tick source: pin rising edge in test mode, else internal 64 Hz
  assign tick = q.external_tick_select ? (i_square_wave_pin && !q.sqw_prev) : i_tick_64hz; // R12 R13
  assign hold = q.stop || q.por; // R22

  rtcc_prescaler u_pre (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_hold(hold),
    .i_tick(tick),
    .o_carry(sec_inc)
  );

  rtcc_bcd_step u_sec (
    .i_val({1'b0, q.sec[6:0]}),
    .i_max(`RTCC_BCD_59),
    .i_min(`RTCC_BCD_ZERO),
    .o_next(sec_next),
    .o_wrap(sec_wrap)
  );

  rtcc_bcd_step u_min (
    .i_val(q.min),
    .i_max(`RTCC_BCD_59),
    .i_min(`RTCC_BCD_ZERO),
    .o_next(min_next),
    .o_wrap(min_wrap)
  );

  rtcc_bcd_step u_hour (
    .i_val(q.hour),
    .i_max(`RTCC_BCD_23),
    .i_min(`RTCC_BCD_ZERO),
    .o_next(hour_next),
    .o_wrap(hour_wrap)
  );

  rtcc_bcd_step u_date (
    .i_val(q.date),
    .i_max(date_max),
    .i_min(`RTCC_BCD_ONE),
    .o_next(date_next),
    .o_wrap(date_wrap)
  );

  rtcc_bcd_step u_mon (
    .i_val({3'h0, q.mon[4:0]}),
    .i_max(`RTCC_BCD_12),
    .i_min(`RTCC_BCD_ONE),
    .o_next(mon_next),
    .o_wrap(mon_wrap)
  );

  rtcc_bcd_step u_year (
    .i_val(q.year),
    .i_max(`RTCC_BCD_99),
    .i_min(`RTCC_BCD_ZERO),
    .o_next(year_next),
    .o_wrap(year_wrap)
  );

  // Carry chain
  assign min_inc = sec_inc && sec_wrap; // R23
  assign hour_inc = min_inc && min_wrap; // R23
  assign day_inc = hour_inc && hour_wrap; // R24
  assign mon_inc = day_inc && date_wrap; // R5
  assign year_inc = mon_inc && mon_wrap; // R6
  assign cent_flip = year_inc && year_wrap; // R8

  // Leap when BCD year divisible by four
  assign leap = q.year[4] ? ((q.year[3:0] == 4'h2) || (q.year[3:0] == 4'h6)) :
                ((q.year[3:0] == 4'h0) || (q.year[3:0] == 4'h4) || (q.year[3:0] == 4'h8)); // R4

  always_comb begin
    unique case (q.mon[4:0])
      5'h02: date_max = leap ? `RTCC_DATE_29 : `RTCC_DATE_28; // R3 R4
      5'h04, 5'h06, 5'h09, 5'h11: date_max = `RTCC_DATE_30; // R3
      default: date_max = `RTCC_DATE_31; // R3
    endcase
  end

  // Alarm compare, disabled fields ignored
  assign any_en = !(q.amin[`RTCC_AE_BIT] && q.ahour[`RTCC_AE_BIT] &&
                    q.adate[`RTCC_AE_BIT] && q.awday[`RTCC_AE_BIT]);
  assign match = any_en &&
                 (q.amin[`RTCC_AE_BIT] || (q.amin[6:0] == q.min[6:0])) &&
                 (q.ahour[`RTCC_AE_BIT] || (q.ahour[5:0] == q.hour[5:0])) &&
                 (q.adate[`RTCC_AE_BIT] || (q.adate[5:0] == q.date[5:0])) &&
                 (q.awday[`RTCC_AE_BIT] || (q.awday[2:0] == q.wday)); // R9
  assign af_set = q.achk && match; // R10 R21

  assign wr = i_reg_wr && !q.por;
  assign cnt_ok = (q.ovcnt >= 8'(`RTCC_OVR_HOLD_CYC)); // R20
  assign ovr_enter = (q.ovst == OV_SCL_HI) && i_sda && i_scl && cnt_ok; // R20

  always_comb begin
    unique case (i_reg_addr)
      `RTCC_ADDR_CS1: rd_mux = {q.external_tick_select, 1'b0, q.stop, 1'b0, q.override_permit, 3'h0};
      `RTCC_ADDR_CS2: rd_mux = {3'h0, q.titp, q.af, q.tf, q.aie, q.tie};
      `RTCC_ADDR_SEC: rd_mux = q.sec;
      `RTCC_ADDR_MIN: rd_mux = q.min;
      `RTCC_ADDR_HOUR: rd_mux = q.hour;
      `RTCC_ADDR_DATE: rd_mux = q.date;
      `RTCC_ADDR_WDAY: rd_mux = {5'h00, q.wday};
      `RTCC_ADDR_MON: rd_mux = q.mon;
      `RTCC_ADDR_YEAR: rd_mux = q.year;
      `RTCC_ADDR_AMIN: rd_mux = q.amin;
      `RTCC_ADDR_AHOUR: rd_mux = q.ahour;
      `RTCC_ADDR_ADATE: rd_mux = q.adate;
      `RTCC_ADDR_AWDAY: rd_mux = q.awday;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    d = q;
    d.sqw_prev = i_square_wave_pin;
    d.sqw_out = i_sqw_source; // R22
    d.achk = min_inc; // R21
    if (sec_inc) begin
      d.sec[6:0] = sec_next[6:0]; // R23
    end
    if (min_inc) begin
      d.min = min_next; // R23
    end
    if (hour_inc) begin
      d.hour = hour_next;
    end
    if (day_inc) begin
      d.date = date_next; // R2 R3 R24
      d.wday = (q.wday >= `RTCC_WDAY_MAX) ? 3'h0 : 3'(q.wday + 3'h1); // R1 R24
    end
    if (mon_inc) begin
      d.mon[4:0] = mon_next[4:0]; // R5 R6
    end
    if (year_inc) begin
      d.year = year_next; // R7
    end
    if (cent_flip) begin
      d.mon[`RTCC_CENT_BIT] = !q.mon[`RTCC_CENT_BIT]; // R8
    end
    // Power-on reset ends when the oscillator is ready
    d.por = q.por && !i_osc_ready;
    // Override sequence: SDA low under SCL high, SCL low, SCL high, SDA high
    d.ovcnt = cnt_ok ? q.ovcnt : 8'(q.ovcnt + 8'h01);
    unique case (q.ovst)
      OV_IDLE: begin
        d.ovcnt = 8'h00;
        if (q.override_permit && i_scl && !i_sda) begin
          d.ovst = OV_SDA_LO; // R19 R20
        end
      end
      OV_SDA_LO: begin
        if (!i_scl && !i_sda && cnt_ok) begin
          d.ovst = OV_SCL_LO;
          d.ovcnt = 8'h00;
        end else if (i_sda || !i_scl) begin
          d.ovst = OV_IDLE;
        end
      end
      OV_SCL_LO: begin
        if (i_scl && !i_sda && cnt_ok) begin
          d.ovst = OV_SCL_HI;
          d.ovcnt = 8'h00;
        end else if (i_sda || i_scl) begin
          d.ovst = OV_IDLE;
        end
      end
      OV_SCL_HI: begin
        if (ovr_enter || i_sda || !i_scl) begin
          d.ovst = OV_IDLE;
        end
      end
    endcase
    if (!q.override_permit) begin
      d.ovst = OV_IDLE; // R19
    end
    if (ovr_enter && q.override_permit) begin
      d.ovr = 1'b1; // R17
      d.por = 1'b0; // R17
    end
    // Register writes override the count in the same cycle
    if (wr) begin
      unique case (i_reg_addr)
        `RTCC_ADDR_CS1: begin
          d.external_tick_select = i_reg_wdata[`RTCC_CS1_EXTERNAL_TICK_SELECT_BIT]; // R12
          d.stop = i_reg_wdata[`RTCC_CS1_STOP_BIT]; // R14
          d.override_permit = i_reg_wdata[`RTCC_CS1_OVERRIDE_PERMIT_BIT];
          if (!i_reg_wdata[`RTCC_CS1_OVERRIDE_PERMIT_BIT]) begin
            d.ovr = 1'b0; // R18
            d.por = q.ovr && !i_osc_ready;
          end
        end
        `RTCC_ADDR_CS2: begin
          d.titp = i_reg_wdata[`RTCC_CS2_TITP_BIT];
          d.tf = i_reg_wdata[`RTCC_CS2_TF_BIT];
          d.aie = i_reg_wdata[`RTCC_CS2_AIE_BIT];
          d.tie = i_reg_wdata[`RTCC_CS2_TIE_BIT];
          if (!i_reg_wdata[`RTCC_CS2_AF_BIT]) begin
            d.af = 1'b0; // R25
          end
        end
        `RTCC_ADDR_SEC: d.sec = i_reg_wdata;
        `RTCC_ADDR_MIN: d.min = {1'b0, i_reg_wdata[6:0]};
        `RTCC_ADDR_HOUR: d.hour = {2'h0, i_reg_wdata[5:0]};
        `RTCC_ADDR_DATE: d.date = {2'h0, i_reg_wdata[5:0]};
        `RTCC_ADDR_WDAY: d.wday = i_reg_wdata[2:0];
        `RTCC_ADDR_MON: d.mon = {i_reg_wdata[7], 2'h0, i_reg_wdata[4:0]};
        `RTCC_ADDR_YEAR: d.year = i_reg_wdata;
        `RTCC_ADDR_AMIN: d.amin = i_reg_wdata;
        `RTCC_ADDR_AHOUR: d.ahour = {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]};
        `RTCC_ADDR_ADATE: d.adate = {i_reg_wdata[7], 1'b0, i_reg_wdata[5:0]};
        `RTCC_ADDR_AWDAY: d.awday = {i_reg_wdata[7], 4'h0, i_reg_wdata[2:0]};
        default: ;
      endcase
    end
    // Hardware set wins over a clear in the same cycle
    if (i_osc_fail) begin
      d.sec[`RTCC_OSF_BIT] = 1'b1;
    end
    if (af_set) begin
      d.af = 1'b1; // R10 R11
    end
    if (i_reg_rd) begin
      d.rdata = rd_mux;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.sec <= `RTCC_SEC_RST;
      q.date <= `RTCC_DATE_RST;
      q.mon <= `RTCC_MON_RST;
      q.amin <= `RTCC_AL_RST;
      q.ahour <= `RTCC_AL_RST;
      q.adate <= `RTCC_AL_RST;
      q.awday <= `RTCC_AL_RST;
      q.override_permit <= `RTCC_OVERRIDE_PERMIT_RST;
      q.por <= 1'b1;
      q.ovst <= OV_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_alarm_hit_flag = q.af;
  assign o_external_tick_mode = q.external_tick_select;
  assign o_por_active = q.por;
  assign o_override_active = q.ovr;
  assign o_square_wave_pin = q.sqw_out;
  assign o_square_wave_pin_oe = !q.external_tick_select; // R12

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_day_step;
    day_inc && !i_reg_wr;
  endsequence

  sequence s_year_roll;
    year_inc && (q.year == `RTCC_BCD_99) && !i_reg_wr;
  endsequence

  property p_wday_wrap;
    s_day_step and (q.wday == 3'h6) |=> (q.wday == 3'h0);
  endproperty
  a_wday_wrap: assert property (p_wday_wrap) else $error("weekday did not wrap to 0"); // R1

  property p_bcd_carry;
    s_day_step and (q.date == 8'h09) |=> (q.date == 8'h10);
  endproperty
  a_bcd_carry: assert property (p_bcd_carry) else $error("date digit not BCD"); // R2

  property p_feb_ordinary;
    s_day_step and (q.mon[4:0] == 5'h02) && (q.date == 8'h28) && !leap |=> (q.date == 8'h01) && (q.mon[4:0] == 5'h03);
  endproperty
  a_feb_ordinary: assert property (p_feb_ordinary) else $error("February 28 did not roll"); // R3 R5

  property p_feb_leap;
    s_day_step and (q.mon[4:0] == 5'h02) && (q.date == 8'h28) && (q.year == 8'h00) |=> (q.date == 8'h29);
  endproperty
  a_feb_leap: assert property (p_feb_leap) else $error("leap February stopped at 28"); // R4

  property p_month_wrap;
    s_day_step and (q.mon[4:0] == 5'h12) && (q.date == 8'h31) |=> (q.mon[4:0] == 5'h01) && (q.year != $past(q.year));
  endproperty
  a_month_wrap: assert property (p_month_wrap) else $error("month wrap did not advance year"); // R6

  property p_year_roll;
    s_year_roll |=> (q.year == 8'h00) && (q.mon[7] != $past(q.mon[7]));
  endproperty
  a_year_roll: assert property (p_year_roll) else $error("year or century roll wrong"); // R7 R8

  property p_minute_roll;
    sec_inc && sec_wrap && (q.min == 8'h59) && !i_reg_wr |=> (q.min == 8'h00);
  endproperty
  a_minute_roll: assert property (p_minute_roll) else $error("minute did not wrap"); // R23

  property p_alarm_field;
    $rose(q.af) |-> $past(q.amin[7] || (q.amin[6:0] == q.min[6:0]));
  endproperty
  a_alarm_field: assert property (p_alarm_field) else $error("alarm set with minute mismatch"); // R9

  property p_alarm_set;
    q.achk && match |=> q.af;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set on match"); // R10

  property p_alarm_cause;
    $rose(q.af) |-> $past(q.achk);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm set without minute step"); // R21

  property p_alarm_hold;
    q.af && !(wr && (i_reg_addr == `RTCC_ADDR_CS2)) |=> q.af;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag dropped by itself"); // R11

  property p_alarm_clear;
    wr && (i_reg_addr == `RTCC_ADDR_CS2) && !i_reg_wdata[3] && !af_set |=> !q.af;
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm flag not cleared by 0"); // R25

  property p_pin_input;
    q.external_tick_select |-> !o_square_wave_pin_oe;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin driven in test mode"); // R12

  property p_override_entry;
    $rose(q.ovr) |-> !q.por && $past(q.override_permit);
  endproperty
  a_override_entry: assert property (p_override_entry) else $error("override entry wrong"); // R17 R19

  property p_override_exit;
    wr && (i_reg_addr == `RTCC_ADDR_CS1) && !i_reg_wdata[3] |=> !q.ovr && !q.override_permit;
  endproperty
  a_override_exit: assert property (p_override_exit) else $error("override not left"); // R18

endmodule : rtcc_calendar_alarm_core

`default_nettype wire

/* File: src/rtcc_params.svh */
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

// Register offsets
`define RTCC_ADDR_CS1 8'h00
`define RTCC_ADDR_CS2 8'h01
`define RTCC_ADDR_SEC 8'h02
`define RTCC_ADDR_MIN 8'h03
`define RTCC_ADDR_HOUR 8'h04
`define RTCC_ADDR_DATE 8'h05
`define RTCC_ADDR_WDAY 8'h06
`define RTCC_ADDR_MON 8'h07
`define RTCC_ADDR_YEAR 8'h08
`define RTCC_ADDR_AMIN 8'h09
`define RTCC_ADDR_AHOUR 8'h0a
`define RTCC_ADDR_ADATE 8'h0b
`define RTCC_ADDR_AWDAY 8'h0c

// Field positions
`define RTCC_CS1_EXTERNAL_TICK_SELECT_BIT 7
`define RTCC_CS1_STOP_BIT 5
`define RTCC_CS1_OVERRIDE_PERMIT_BIT 3
`define RTCC_CS2_TITP_BIT 4
`define RTCC_CS2_AF_BIT 3
`define RTCC_CS2_TF_BIT 2
`define RTCC_CS2_AIE_BIT 1
`define RTCC_CS2_TIE_BIT 0
`define RTCC_OSF_BIT 7
`define RTCC_CENT_BIT 7
`define RTCC_AE_BIT 7

// Reset values
`define RTCC_SEC_RST 8'h80
`define RTCC_DATE_RST 8'h01
`define RTCC_MON_RST 8'h01
`define RTCC_AL_RST 8'h80
`define RTCC_OVERRIDE_PERMIT_RST 1'b1

// Counter limits in BCD
`define RTCC_BCD_ZERO 8'h00
`define RTCC_BCD_ONE 8'h01
`define RTCC_BCD_59 8'h59
`define RTCC_BCD_23 8'h23
`define RTCC_BCD_12 8'h12
`define RTCC_BCD_99 8'h99
`define RTCC_DATE_31 8'h31
`define RTCC_DATE_30 8'h30
`define RTCC_DATE_29 8'h29
`define RTCC_DATE_28 8'h28
`define RTCC_WDAY_MAX 3'h6

// Prescaler
`define RTCC_PRE_CARRY_AT 6'h1f

// Timing
`define RTCC_CLK_PERIOD_NS 8
`define RTCC_OVR_HOLD_NS 1000
`define RTCC_OVR_HOLD_CYC ((`RTCC_OVR_HOLD_NS + `RTCC_CLK_PERIOD_NS - 1) / `RTCC_CLK_PERIOD_NS)

`endif

/* File: src/rtcc_pkg.sv */
package rtcc_pkg;

  typedef enum logic [1:0] {OV_IDLE, OV_SDA_LO, OV_SCL_LO, OV_SCL_HI} rtcc_ovr_t;

  typedef struct packed {
    logic [5:0] count;
  } rtcc_pre_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [2:0] wday;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] amin;
    logic [7:0] ahour;
    logic [7:0] adate;
    logic [7:0] awday;
    logic external_tick_select;
    logic stop;
    logic override_permit;
    logic titp;
    logic tf;
    logic aie;
    logic tie;
    logic af;
    logic achk;
    logic por;
    logic ovr;
    rtcc_ovr_t ovst;
    logic [7:0] ovcnt;
    logic sqw_prev;
    logic sqw_out;
    logic [7:0] rdata;
  } rtcc_state_t;

endpackage : rtcc_pkg

/* File: src/rtcc_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
`include "rtcc_params.svh"

module rtcc_prescaler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_hold,
  input wire logic i_tick,
  // Seconds carry
  output logic o_carry
);
  import rtcc_pkg::*;

  rtcc_pre_t q;
  rtcc_pre_t d;

  always_comb begin
    d = q;
    if (i_hold) begin
      d.count = 6'h00; // R14 R22
    end else if (i_tick) begin
      d.count = 6'(q.count + 6'h01);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Carry on the 31 to 32 step: first after 32 ticks, then every 64
  assign o_carry = !i_hold && i_tick && (q.count == `RTCC_PRE_CARRY_AT); // R13 R15

  // Ticks seen since hold release or last carry
  logic [6:0] hc_q;
  logic first_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hc_q <= 7'h00;
      first_q <= 1'b1;
    end else if (i_hold) begin
      hc_q <= 7'h00;
      first_q <= 1'b1;
    end else if (o_carry) begin
      hc_q <= 7'h00;
      first_q <= 1'b0;
    end else if (i_tick) begin
      hc_q <= 7'(hc_q + 7'h01);
    end
  end

  property p_pre_hold;
    @(posedge i_clk) disable iff (i_sys_rst) i_hold |=> (q.count == 6'h00);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("prescaler not held at zero"); // R14

  property p_first_carry;
    @(posedge i_clk) disable iff (i_sys_rst) (o_carry && first_q) |-> (hc_q == 7'h1f);
  endproperty
  a_first_carry: assert property (p_first_carry) else $error("first carry not on 32nd tick"); // R15

  property p_next_carry;
    @(posedge i_clk) disable iff (i_sys_rst) (o_carry && !first_q) |-> (hc_q == 7'h3f);
  endproperty
  a_next_carry: assert property (p_next_carry) else $error("carry spacing not 64 ticks"); // R13

endmodule : rtcc_prescaler

`default_nettype wire
